/* hw/zcb_decode.sv */
/*
 * Combinational decode of one instruction word into a comparison kind,
 * likely and link flags. Assumes the word is stable while valid is high.
 */
`timescale 1ns/100ps
`default_nettype none
module zcb_decode
(
	input  wire logic [31:0]      instr,
	output zcb_pkg::cmp_kind_t    kind,
	output logic                  likely,
	output logic                  link
);
	logic [5:0] opcode;
	logic [4:0] sub;

	assign opcode = instr[zcb_pkg::OP_HI:zcb_pkg::OP_LO];
	assign sub    = instr[zcb_pkg::SUB_HI:zcb_pkg::SUB_LO];

	always_comb
	begin
		kind   = zcb_pkg::CMP_NONE;
		likely = 1'b0;
		link   = 1'b0;
		case (opcode)
			zcb_pkg::OPC_BRANCH_GREATER_THAN_ZERO:        kind = zcb_pkg::CMP_GTZ;
			zcb_pkg::OPC_BRANCH_LESS_EQUAL_ZERO:        kind = zcb_pkg::CMP_LEZ;
			zcb_pkg::OPC_BRANCH_GREATER_THAN_ZERO_LIKELY:
			begin
				kind   = zcb_pkg::CMP_GTZ;
				likely = 1'b1;
			end
			zcb_pkg::OPC_BRANCH_LESS_EQUAL_ZERO_LIKELY:
			begin
				kind   = zcb_pkg::CMP_LEZ;
				likely = 1'b1;
			end
			zcb_pkg::OPC_REGISTER_IMMEDIATE_OPCODE_CLASS:
			begin
				case (sub)
					zcb_pkg::SUB_LTZ:        kind = zcb_pkg::CMP_LTZ;
					zcb_pkg::SUB_LTZ_LIKELY:
					begin
						kind   = zcb_pkg::CMP_LTZ;
						likely = 1'b1;
					end
					zcb_pkg::SUB_LTZ_LINK:
					begin
						kind = zcb_pkg::CMP_LTZ;
						link = 1'b1;
					end
					zcb_pkg::SUB_LTZ_LINK_L:
					begin
						kind   = zcb_pkg::CMP_LTZ;
						likely = 1'b1;
						link   = 1'b1;
					end
					default: kind = zcb_pkg::CMP_NONE;
				endcase
			end
			default: kind = zcb_pkg::CMP_NONE;
		endcase
	end
endmodule : zcb_decode
`default_nettype wire

/* hw/zero_compare_branch_unit.sv */
/*
 * Zero-compare branch resolution: decodes a branch in its own cycle,
 * resolves condition and target, and on the next edge presents the
 * PC redirect, delay-slot squash and link write as registered outputs.
 * Assumes the pipeline issues the delay-slot instruction in the step
 * after a branch and applies redirect/squash to that step.
 */
`timescale 1ns/100ps
`default_nettype none
module zero_compare_branch_unit
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr,
	input  wire logic [63:0] branch_pc,
	input  wire logic [63:0] source_value,
	input  wire logic        mode_64,
	output logic             branch_resolved,
	output logic             branch_taken,
	output logic [63:0]      redirect_pc,
	output logic             delay_slot_squash,
	output logic             link_write,
	output logic [4:0]       link_reg,
	output logic [63:0]      link_value,
	output logic [4:0]       source_register_field
);
	zcb_pkg::cmp_kind_t kind;
	logic               likely;
	logic               link;
	logic               is_branch;
	logic               cond;
	logic               sign_bit;
	logic               is_zero;
	logic [63:0]        disp;
	logic [63:0]        next_target;
	logic [63:0]        next_link;

	// narrows a value to 32 bits sign-extended when not in 64-bit mode
	function automatic logic [63:0] fit_width(input logic [63:0] v, input logic wide);
		fit_width = wide ? v : {{32{v[zcb_pkg::SIGN32]}}, v[31:0]};
	endfunction : fit_width

	zcb_decode u_decode
	(
		.instr  (instr),
		.kind   (kind),
		.likely (likely),
		.link   (link)
	);

	assign is_branch = instr_valid && (kind != zcb_pkg::CMP_NONE);

	assign sign_bit = mode_64 ? source_value[zcb_pkg::SIGN64] : source_value[zcb_pkg::SIGN32];
	assign is_zero  = mode_64 ? (source_value == '0) : (source_value[31:0] == 32'h0000_0000);

	always_comb
	begin
		case (kind)
			zcb_pkg::CMP_GTZ: cond = !sign_bit && !is_zero;
			zcb_pkg::CMP_LEZ: cond = sign_bit || is_zero;
			zcb_pkg::CMP_LTZ: cond = sign_bit;
			default:          cond = 1'b0;
		endcase
	end

	assign disp = {{(zcb_pkg::XLEN - 18){instr[zcb_pkg::OFS_HI]}}, instr[zcb_pkg::OFS_HI:0],
		2'b00};
	assign next_target = fit_width(branch_pc + zcb_pkg::DELAY_OFS + disp, mode_64);
	assign next_link   = fit_width(branch_pc + zcb_pkg::LINK_OFS, mode_64);

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			branch_resolved <= 1'b0;
			branch_taken    <= 1'b0;
			redirect_pc     <= zcb_pkg::ADDR_RESET;
		end
		else
		begin
			branch_resolved <= is_branch;
			branch_taken    <= is_branch && cond;
			redirect_pc     <= next_target;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			delay_slot_squash <= 1'b0;
		else
			delay_slot_squash <= is_branch && likely && !cond;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			link_write <= 1'b0;
			link_reg   <= zcb_pkg::LINK_REG;
			link_value <= zcb_pkg::ADDR_RESET;
		end
		else
		begin
			link_write <= is_branch && link;
			link_reg   <= zcb_pkg::LINK_REG;
			link_value <= next_link;
		end
	end

	// source r31 not trapped; field passed through only
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			source_register_field <= 5'h00;
		else
			source_register_field <= instr[zcb_pkg::RS_HI:zcb_pkg::RS_LO];
	end
endmodule : zero_compare_branch_unit
`default_nettype wire

/* pkg/zcb_pkg.sv */
/*
 * Constants, opcode encodings and the branch-kind enum for the
 * zero-compare branch unit. Assumes a 64-bit core whose fetch logic
 * presents the branch's own address alongside the instruction word.
 */
// Behaviour
// - target is delay-slot address plus scaled displacement.
// - displacement shifted left two, sign-extended from bit 15 to address width.
// - greater-than-zero: taken when sign bit clear and value nonzero.
// - less-or-equal-zero: taken when sign bit set or value zero.
// - less-than-zero family: taken whenever sign bit set.
// - taken branch still runs the one delay-slot instruction first.
// - condition and target formed in branch cycle; PC redirected next step.
// - likely forms squash the delay slot when not taken.
// - link forms always write branch address plus eight into register 31.
// - source register 31 on a link branch is illegal but never trapped.
// - less-than-zero-and-link decodes from opcode 000001, sub-code 10000.
package zcb_pkg;
	localparam int          XLEN            = 64;
	localparam int          OP_HI           = 31;
	localparam int          OP_LO           = 26;
	localparam int          RS_HI           = 25;
	localparam int          RS_LO           = 21;
	localparam int          SUB_HI          = 20;
	localparam int          SUB_LO          = 16;
	localparam int          OFS_HI          = 15;
	localparam int          SIGN32          = 31;
	localparam int          SIGN64          = 63;
	localparam int          WORD_SHIFT      = 2;
	localparam logic [5:0]  OPC_REGISTER_IMMEDIATE_OPCODE_CLASS      = 6'h01;
	localparam logic [5:0]  OPC_BRANCH_LESS_EQUAL_ZERO        = 6'h06;
	localparam logic [5:0]  OPC_BRANCH_GREATER_THAN_ZERO        = 6'h07;
	localparam logic [5:0]  OPC_BRANCH_LESS_EQUAL_ZERO_LIKELY = 6'h16;
	localparam logic [5:0]  OPC_BRANCH_GREATER_THAN_ZERO_LIKELY = 6'h17;
	localparam logic [4:0]  SUB_LTZ         = 5'h00;
	localparam logic [4:0]  SUB_LTZ_LIKELY  = 5'h02;
	localparam logic [4:0]  SUB_LTZ_LINK    = 5'h10;
	localparam logic [4:0]  SUB_LTZ_LINK_L  = 5'h12;
	localparam logic [4:0]  LINK_REG        = 5'h1f;
	localparam logic [63:0] DELAY_OFS       = 64'h0000_0000_0000_0004;
	localparam logic [63:0] LINK_OFS        = 64'h0000_0000_0000_0008;
	localparam logic [63:0] ADDR_RESET      = 64'h0000_0000_0000_0000;

	typedef enum logic [1:0]
	{
		CMP_NONE = 2'b00,
		CMP_GTZ  = 2'b01,
		CMP_LEZ  = 2'b11,
		CMP_LTZ  = 2'b10
	} cmp_kind_t;
endpackage : zcb_pkg

/* verif/zcb_fetch_model.sv */
/* fetch side: steps the branch address, follows redirects
   assumes the unit's registered outputs */
`timescale 1ns/100ps
`default_nettype none
module zcb_fetch_model
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        branch_taken,
	input wire logic [63:0] redirect_pc,
	output logic [63:0]     fetch_pc
);
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			fetch_pc <= 64'h0;
		else
			fetch_pc <= branch_taken ? redirect_pc : fetch_pc + 64'h4;
endmodule : zcb_fetch_model
`default_nettype wire

/* verif/zcb_properties.sv */
/* checker for the branch unit ports
   assumes it is bound to the unit's top */
`timescale 1ns/100ps
`default_nettype none
module zcb_properties
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        instr_valid,
	input wire logic [31:0] instr,
	input wire logic [63:0] branch_pc,
	input wire logic [63:0] source_value,
	input wire logic        mode_64,
	input wire logic        branch_resolved,
	input wire logic        branch_taken,
	input wire logic [63:0] redirect_pc,
	input wire logic        delay_slot_squash,
	input wire logic        link_write,
	input wire logic [4:0]  link_reg,
	input wire logic [63:0] link_value
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic [5:0] op = instr[31:26];
	wire logic [4:0] sub = instr[20:16];
	wire logic       go = instr_valid && mode_64;
	wire logic       pos = !source_value[63] && |source_value;
	a_link_reg_fixed: assert property (link_reg == 5'h1f)
		else $error("link reg");
	a_link_decode: assert property (instr_valid && op == 6'h01 && sub == 5'h10 |=> link_write)
		else $error("link decode");
	a_link_value: assert property (link_write && $past(mode_64) |-> link_value == $past(branch_pc) + 64'h8)
		else $error("link value");
	a_ltz_taken: assert property (go && op == 6'h01 && sub == 5'h00 |=> branch_taken == $past(source_value[63]))
		else $error("ltz");
	a_gtz_taken: assert property (go && op == 6'h07 |=> branch_taken == $past(pos))
		else $error("gtz");
	a_lez_taken: assert property (go && op == 6'h06 |=> branch_taken != $past(pos))
		else $error("lez");
	a_squash_cause: assert property (delay_slot_squash |-> branch_resolved && !branch_taken)
		else $error("squash");
	a_target_sum: assert property (branch_taken && $past(mode_64) |-> redirect_pc == $past(branch_pc) + 64'h4 + {{46{$past(instr[15])}}, $past(instr[15:0]), 2'h0})
		else $error("target");
endmodule : zcb_properties
bind zero_compare_branch_unit zcb_properties u_props (.*);
`default_nettype wire

/* verif/zero_compare_branch_unit_tb_top.sv */
/* random branch words checked against a model each cycle
   assumes the fetch model drives branch_pc */
`timescale 1ns/100ps
`default_nettype none
module zero_compare_branch_unit_tb_top;
	logic        clk = 0;
	logic        sys_rst = 1;
	logic        iv = 0;
	logic        m64 = 0;
	logic [31:0] ins = 0;
	logic [63:0] src = 0;
	wire logic [63:0] pc;
	logic        res, tak, sq, lw;
	logic [4:0]  lreg;
	logic [63:0] rpc, lval;
	int          mismatches = 0;
	int          tests_run = 0;
	logic [10:0] enc [9] = '{11'h020, 11'h022, 11'h030, 11'h032, 11'h0c0, 11'h0e0, 11'h2c0, 11'h2e0, 11'h0};
	always #2 clk = ~clk;
	zero_compare_branch_unit uut (.clk(clk), .sys_rst(sys_rst), .instr_valid(iv), .instr(ins),
		.branch_pc(pc), .source_value(src), .mode_64(m64), .branch_resolved(res),
		.branch_taken(tak), .redirect_pc(rpc), .delay_slot_squash(sq), .link_write(lw),
		.link_reg(lreg), .link_value(lval), .source_register_field());
	zcb_fetch_model fm (.clk(clk), .sys_rst(sys_rst), .branch_taken(tak), .redirect_pc(rpc), .fetch_pc(pc));
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
		tests_run++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic complete_run;
		$display("tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	initial
	begin
		#4000 mismatches++;
		complete_run;
	end
	initial
	begin
		logic [63:0] ep, el, sv;
		logic s, c, er, lk;
		int k;
		void'($urandom(51120));
		repeat (5) @(negedge clk);
		sys_rst = 0;
		repeat (400)
		begin
			k = $urandom % 9;
			iv = ($urandom % 8) != 0;
			m64 = 1'($urandom);
			ins = {enc[k][10:5], 5'($urandom), enc[k][4:0], 16'($urandom)};
			src = ($urandom % 3 == 0) ? 64'h0 : {32'($urandom), 32'($urandom % 2 * $urandom)};
			// expectations use pc before the sampling edge, as the unit sees it
			// mode picks width
			sv = m64 ? src : 64'(signed'(src[31:0]));
			s = sv[63];
			c = k < 4 ? s : (k == 4 || k == 6) ? s || sv == 0 : !s && sv != 0;
			er = iv && k < 8;
			lk = iv && (k == 2 || k == 3);
			ep = pc + 64'h4 + {{46{ins[15]}}, ins[15:0], 2'h0};
			el = pc + 64'h8;
			if (!m64)
			begin
				ep = 64'(signed'(ep[31:0]));
				el = 64'(signed'(el[31:0]));
			end
			@(negedge clk);
			chk("resolved", 64'(er), 64'(res));
			chk("taken", 64'(er && c), 64'(tak));
			chk("squash", 64'(er && !c && (k == 1 || k == 3 || k > 5)), 64'(sq));
			chk("link", 64'(lk), 64'(lw));
			chk("linkreg", 64'h1f, 64'(lreg));
			chk("srcfield", 64'(ins[25:21]), 64'(uut.source_register_field));
			if (er && c)
				chk("target", ep, rpc);
			if (lk)
				chk("linkval", el, lval);
		end
		$display("random branch test done");
		complete_run;
	end
endmodule : zero_compare_branch_unit_tb_top
`default_nettype wire
